/* verilog/fram_pkg.sv */
/*
 * Shared constants for the two-wire serial byte memory slave:
 * array geometry, slave address field layout and state encoding.
 * Assumes a 40 MHz system clock well above the serial clock rate.
 */
package fram_pkg;

	// -------------------------------------------------------------
	// Array geometry
	// -------------------------------------------------------------
	localparam int DATA_WIDTH = 8;
	localparam int ADDR_WIDTH = 9;
	localparam int MEM_DEPTH = 512;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [8:0] ADDR_RESET = 9'h000;
	localparam logic [8:0] ADDR_STEP = 9'h001;

	// -------------------------------------------------------------
	// Slave address byte layout
	// -------------------------------------------------------------
	localparam int TYPE_HI = 7;
	localparam int TYPE_LO = 4;
	localparam int SEL_HI = 3;
	localparam int SEL_LO = 2;
	localparam int PAGE_POS = 1;
	localparam int RW_POS = 0;
	localparam int PAGE_MSB = 8;

	// -------------------------------------------------------------
	// Serial clock rates and sampling budget
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_MAX_PERIOD_NS = 1000;
	localparam int SCL_CYCLES_MIN = SCL_MAX_PERIOD_NS / CLK_PERIOD_NS;

	// -------------------------------------------------------------
	// Protocol states
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		IDLE = 4'h0,
		DEV = 4'h1,
		DEV_ACK = 4'h2,
		WADDR = 4'h3,
		WADDR_ACK = 4'h4,
		WDATA = 4'h5,
		WDATA_ACK = 4'h6,
		RDATA = 4'h7,
		RDATA_ACK = 4'h8
	} state_type;

endpackage

/* verilog/byte_array.sv */
/*
 * Byte storage array with one write port and a registered read.
 * Assumes writes and reads share one address and that the
 * contents need no reset.
 */
`timescale 1ns/1ps
module byte_array #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] cells [DEPTH];

	// -------------------------------------------------------------
	// Write and registered read
	// -------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (ce && we) begin
			cells[addr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			rdata <= cells[addr];
		end
	end

endmodule

/* verilog/fram_serial_slave.sv */
/*
 * Two-wire serial slave front end for a 512 x 8 byte memory.
 * Holds the protocol engine, address latch and line driver.
 * Assumes the serial data line has an external pull-up, the pads
 * pull straps and write-protect low, and clk runs far above scl.
 */
`timescale 1ns/1ps
module fram_serial_slave import fram_pkg::*; #(
	// Device type code; value is arbitrary
	parameter logic [3:0] DEVICE_TYPE = 4'h5
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [1:0] device_select_straps,
	input wire logic wp
);

	state_type state;
	logic [2:0] cnt;
	logic [7:0] shifter;
	logic [7:0] tx;
	logic [8:0] addr;
	logic ack_on;
	logic page;
	logic drive;
	logic rx_bit;
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic wp_s1, wp_s;
	logic [1:0] strap_s1, strap_s;
	logic rise_ev, fall_ev, start_ev, stop_ev;
	logic [7:0] rx_byte;
	logic last_bit, dev_match, mem_we;
	logic [7:0] mem_rdata;

	// -------------------------------------------------------------
	// Link clock domain
	// -------------------------------------------------------------
	// Data bit captured on the serial clock's own rising edge
	always_ff @(posedge scl) begin
		rx_bit <= sda_in;
	end

	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	// Two flops per pin; the third scl and sda flops feed edge finders
	always_ff @(posedge clk) begin
		if (ce) begin
			scl_s1 <= scl;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	// Pulled-down straps and protect pin arrive low when left open
	always_ff @(posedge clk) begin
		if (ce) begin
			wp_s1 <= wp;
			wp_s <= wp_s1;
			strap_s1 <= device_select_straps;
			strap_s <= strap_s1;
		end
	end

	// Bus events; 40 clocks per bit at 1 MHz leave ample margin
	assign rise_ev = scl_s2 && !scl_s3;
	assign fall_ev = !scl_s2 && scl_s3;
	assign start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_ev = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

	// -------------------------------------------------------------
	// Byte decode
	// -------------------------------------------------------------
	assign rx_byte = {shifter[6:0], rx_bit};
	assign last_bit = rise_ev && (cnt == BIT_LAST);
	assign dev_match = (rx_byte[TYPE_HI:TYPE_LO] == DEVICE_TYPE) &&
		(rx_byte[SEL_HI:SEL_LO] == strap_s);

	// Array write strobe on the 8th data bit unless protected
	assign mem_we = ce && !start_ev && !stop_ev && last_bit &&
		(state == WDATA) && !wp_s;

	// -------------------------------------------------------------
	// Bit counter and receive shifter
	// -------------------------------------------------------------
	// Bytes move MSB first, one bit per scl rise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= BIT_FIRST;
			shifter <= 8'h00;
		end else if (ce) begin
			if (start_ev || stop_ev) begin
				cnt <= BIT_FIRST;
			end else if (rise_ev && (state == DEV || state == WADDR ||
				state == WDATA || state == RDATA)) begin
				shifter <= rx_byte;
				cnt <= cnt + 3'h1;
			end
		end
	end

	// -------------------------------------------------------------
	// Protocol state machine
	// -------------------------------------------------------------
	// Start or stop aborts anything in flight
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= IDLE;
			ack_on <= 1'h0;
			page <= 1'h0;
		end else if (ce) begin
			if (start_ev) begin
				state <= DEV;
				ack_on <= 1'h0;
			end else if (stop_ev) begin
				state <= IDLE;
				ack_on <= 1'h0;
			end else begin
				unique case (state)
				IDLE: begin
					ack_on <= 1'h0;
				end
				DEV: begin
					if (last_bit) begin
						if (dev_match) begin
							state <= DEV_ACK;
							page <= rx_byte[PAGE_POS];
						end else begin
							state <= IDLE;
						end
					end
				end
				WADDR: begin
					if (last_bit) begin
						state <= WADDR_ACK;
					end
				end
				WDATA: begin
					if (last_bit) begin
						state <= WDATA_ACK;
					end
				end
				RDATA: begin
					if (last_bit) begin
						state <= RDATA_ACK;
						ack_on <= 1'h0;
					end
				end
				DEV_ACK, WADDR_ACK, WDATA_ACK: begin
					if (fall_ev) begin
						ack_on <= !ack_on;
						if (ack_on && state == DEV_ACK) begin
							state <= shifter[RW_POS] ? RDATA : WADDR;
						end else if (ack_on) begin
							state <= WDATA;
						end
					end
				end
				RDATA_ACK: begin
					if (rise_ev && rx_bit) begin
						state <= IDLE;
					end else if (rise_ev) begin
						ack_on <= 1'h1;
					end else if (fall_ev && ack_on) begin
						state <= RDATA;
						ack_on <= 1'h0;
					end
				end
				default: begin
					state <= IDLE;
				end
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Address latch
	// -------------------------------------------------------------
	// Word address loads on writes; page bit loads on reads
	always_ff @(posedge clk) begin
		if (!nrst) begin
			addr <= ADDR_RESET;
		end else if (ce && !start_ev && !stop_ev) begin
			if (state == DEV && last_bit && dev_match &&
				rx_byte[RW_POS]) begin
				addr[PAGE_MSB] <= rx_byte[PAGE_POS];
			end else if (state == WADDR && last_bit) begin
				addr <= {page, rx_byte};
			end else if ((state == WDATA || state == RDATA) && last_bit) begin
				addr <= addr + ADDR_STEP;
			end
		end
	end

	// -------------------------------------------------------------
	// Line driver
	// -------------------------------------------------------------
	// Drive changes on an scl fall, or clears on start or stop, so data moves while scl is low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			drive <= 1'h0;
			tx <= 8'h00;
		end else if (ce) begin
			if (start_ev || stop_ev) begin
				drive <= 1'h0;
			end else if (fall_ev) begin
				unique case (state)
				DEV_ACK, WADDR_ACK, WDATA_ACK: begin
					// Pull low for the ninth clock, release after it
					drive <= !ack_on;
					if (ack_on && state == DEV_ACK && shifter[RW_POS]) begin
						tx <= mem_rdata;
						drive <= !mem_rdata[TYPE_HI];
					end
				end
				RDATA: begin
					drive <= !tx[BIT_LAST - cnt];
				end
				RDATA_ACK: begin
					drive <= 1'h0;
					if (ack_on) begin
						tx <= mem_rdata;
						drive <= !mem_rdata[TYPE_HI];
					end
				end
				default: begin
					drive <= 1'h0;
				end
				endcase
			end
		end
	end

	// Open drain: output level fixed low, enable low while pulling
	assign sda_out = 1'h0;
	assign sda_oe_n = !drive;

	// -------------------------------------------------------------
	// Storage
	// -------------------------------------------------------------
	byte_array #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(MEM_DEPTH),
		.AW(ADDR_WIDTH)
	) array_u (
		.clk(clk),
		.ce(ce),
		.we(mem_we),
		.addr(addr),
		.wdata(rx_byte),
		.rdata(mem_rdata)
	);

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	sequence s_eighth_write;
		ce && state == WDATA && last_bit && !start_ev && !stop_ev;
	endsequence

	sequence s_into_ack;
		ce && mem_we ##1 state == WDATA_ACK;
	endsequence

	property p_match;
		@(posedge clk) disable iff (!nrst)
		state == DEV_ACK |-> shifter[SEL_HI:SEL_LO] == strap_s &&
			shifter[TYPE_HI:TYPE_LO] == DEVICE_TYPE;
	endproperty
	a_match: assert property (p_match)
		else $error("Acknowledged a foreign slave address");

	property p_protect;
		@(posedge clk) disable iff (!nrst)
		wp_s |-> !mem_we;
	endproperty
	a_protect: assert property (p_protect)
		else $error("Array written while protected");

	property p_commit;
		@(posedge clk) disable iff (!nrst)
		s_eighth_write and !wp_s |-> mem_we;
	endproperty
	a_commit: assert property (p_commit)
		else $error("Data byte not committed on 8th bit");

	property p_ready;
		@(posedge clk) disable iff (!nrst)
		s_into_ack |-> !mem_we;
	endproperty
	a_ready: assert property (p_ready)
		else $error("Write did not finish within its byte");

	property p_increment;
		@(posedge clk) disable iff (!nrst)
		s_into_ack |-> addr == $past(addr) + ADDR_STEP;
	endproperty
	a_increment: assert property (p_increment)
		else $error("Address latch did not step after data byte");

	property p_drive_on_fall;
		@(posedge clk) disable iff (!nrst)
		$changed(drive) |-> $past(fall_ev || start_ev || stop_ev);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall)
		else $error("Data line changed away from an scl fall");

	property p_read_page;
		@(posedge clk) disable iff (!nrst)
		state == DEV_ACK && shifter[RW_POS] |->
			addr[PAGE_MSB] == shifter[PAGE_POS];
	endproperty
	a_read_page: assert property (p_read_page)
		else $error("Read page bit not taken from slave address");

	property p_abort;
		@(posedge clk) disable iff (!nrst)
		ce && (start_ev || stop_ev) |=> !drive ##1 !mem_we;
	endproperty
	a_abort: assert property (p_abort)
		else $error("Line held or array written after start or stop");

	property p_idle_release;
		@(posedge clk) disable iff (!nrst)
		state == IDLE |-> sda_oe_n && sda_out == 1'h0;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("Data line pulled while idle");

	property p_reset;
		@(posedge clk)
		!nrst |=> state == IDLE && addr == ADDR_RESET && !drive;
	endproperty
	a_reset: assert property (p_reset)
		else $error("Reset left interface state undefined");

endmodule

/* testbench/i2c_master_model.sv */
/*
 * Two-wire bus master model: drives scl and releases or pulls data.
 * Assumes the bench wire-ANDs sda_m with the slave and a pull-up.
 */
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_m
);
	// Quarter serial period in clk cycles, set by the bench
	int q = 10;
	// scl idles high and stands still between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// ---------------------------------------------------------
	// Bus conditions and bits
	// ---------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data falls while scl high
	task automatic start_cond();
		sda_m <= 1'b1;
		tick(q);
		scl <= 1'b1;
		tick(q);
		sda_m <= 1'b0;
		tick(q);
		scl <= 1'b0;
		tick(q);
	endtask
	// Data rises while scl high
	task automatic stop_cond();
		sda_m <= 1'b0;
		tick(q);
		scl <= 1'b1;
		tick(q);
		sda_m <= 1'b1;
		tick(q);
	endtask
	// Data changes only while scl low
	task automatic put_bit(input logic b);
		sda_m <= b;
		tick(q);
		scl <= 1'b1;
		tick(2 * q);
		scl <= 1'b0;
		tick(q);
	endtask
	// Sampled in the middle of the high phase
	task automatic get_bit(output logic b);
		sda_m <= 1'b1;
		tick(q);
		scl <= 1'b1;
		tick(q);
		b = sda_line;
		tick(q);
		scl <= 1'b0;
		tick(q);
	endtask
	// Bytes go MSB first; ack is returned high when the line was low
	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(ack);
		ack = ~ack;
	endtask
	task automatic get_byte(input logic more, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(~more);
	endtask
endmodule

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the two-wire serial byte memory slave.
 * Assumes fram_pkg and the master model in i2c_master_model.sv.
 */
`timescale 1ns/1ps
module tb_top;
	import fram_pkg::*;
	// Device type code; value is arbitrary
	localparam logic [3:0] dev_type = 4'h5;
	logic clk, nrst, wp, scl, sda_m, sda_out, sda_oe_n;
	logic [1:0] device_select_straps;
	logic [15:0] seed = 16'h73a5;
	logic [7:0] mem [MEM_DEPTH];
	logic [8:0] latch;
	int mismatches = 0;
	int samples_checked = 0;
	wire logic sda_line;
	// Open-drain wire with pull-up
	assign sda_line = sda_m & (sda_oe_n | sda_out);
	fram_serial_slave #(.DEVICE_TYPE(dev_type)) dut (
		.clk(clk),
		.ce(1'b1),
		.nrst(nrst),
		.scl(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.device_select_straps(device_select_straps),
		.wp(wp)
	);
	i2c_master_model master (
		.clk(clk),
		.sda_line(sda_line),
		.scl(scl),
		.sda_m(sda_m)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (99000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	// ---------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction
	function automatic logic [7:0] addr_byte(input logic [1:0] sel,
		input logic page, input logic rw);
		return {dev_type, sel, page, rw};
	endfunction
	task automatic do_reset(input int n);
		nrst <= 1'b0;
		repeat (n) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		latch = ADDR_RESET;
		check({7'h00, sda_oe_n}, 8'h01);
		check({7'h00, sda_out}, 8'h00);
	endtask
	// Write n random bytes from address a; n of 0 only loads the latch
	task automatic wr(input logic [1:0] sel, input logic [8:0] a,
		input int n, input logic exp_ack);
		logic ack;
		logic [7:0] d;
		master.start_cond();
		master.put_byte(addr_byte(sel, a[8], 1'b0), ack);
		check({7'h00, ack}, {7'h00, exp_ack});
		if (ack === 1'b1) begin
			master.put_byte(a[7:0], ack);
			check({7'h00, ack}, 8'h01);
			latch = a;
			for (int i = 0; i < n; i++) begin
				d = 8'(rnd());
				master.put_byte(d, ack);
				check({7'h00, ack}, 8'h01);
				if (wp !== 1'b1) mem[latch] = d;
				latch = latch + ADDR_STEP;
			end
		end
		master.stop_cond();
	endtask
	// Read n bytes from the latch with the page bit replaced
	task automatic rd(input logic [1:0] sel, input logic page, input int n);
		logic ack;
		logic [7:0] d;
		master.start_cond();
		master.put_byte(addr_byte(sel, page, 1'b1), ack);
		check({7'h00, ack}, 8'h01);
		latch[PAGE_MSB] = page;
		for (int i = 0; i < n; i++) begin
			master.get_byte(i < n - 1, d);
			check(d, mem[latch]);
			latch = latch + ADDR_STEP;
		end
		master.stop_cond();
	endtask
	// ---------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------
	initial begin
		logic ack;
		logic [8:0] a;
		int rate [4] = '{25, 100, 10, 10};
		nrst = 1'b0;
		wp = 1'b0;
		device_select_straps = 2'h0;
		do_reset(10);
		// Every strap setting at 400 kHz, 100 kHz and 1 MHz
		for (int s = 0; s < 4; s++) begin
			master.q = rate[s];
			device_select_straps <= 2'(s);
			a = 9'(rnd());
			wr(2'(s + 1), a, 1, 1'b0);
			master.start_cond();
			master.put_byte({~dev_type, 2'(s), 2'h0}, ack);
			check({7'h00, ack}, 8'h00);
			master.stop_cond();
			wr(2'(s), a, 2, 1'b1);
			wr(2'(s), a, 0, 1'b1);
			rd(2'(s), a[8], 2);
		end
		// Wrap from the top location to the bottom
		wr(2'h3, 9'h1ff, 2, 1'b1);
		wr(2'h3, 9'h1ff, 0, 1'b1);
		rd(2'h3, 1'b1, 2);
		// Protected writes are acked but change nothing
		a = 9'(rnd());
		wr(2'h3, a, 2, 1'b1);
		wp <= 1'b1;
		wr(2'h3, a, 2, 1'b1);
		wp <= 1'b0;
		wr(2'h3, a, 0, 1'b1);
		rd(2'h3, a[8], 2);
		// Start after five data bits leaves the byte alone
		master.start_cond();
		master.put_byte(addr_byte(2'h3, a[8], 1'b0), ack);
		master.put_byte(a[7:0], ack);
		for (int i = 7; i > 2; i--) master.put_bit(~mem[a][i]);
		master.start_cond();
		master.stop_cond();
		wr(2'h3, a, 0, 1'b1);
		rd(2'h3, a[8], 1);
		// Reset in mid-run clears the latch
		do_reset(2);
		rd(2'h3, 1'b0, 1);
		give_verdict();
	end
endmodule
